// >>> fskh_ctrl.v
// host-side controller that runs whole transmit and receive frames on a
// 4-level fsk packet modem through its parallel port and interrupt line.
// assumes the device pins are asynchronous to MCLK; software drives the
// plain register port on MCLK.
//
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "fskh_regs.vh"

// How it works
// - before transmit load divider, set irq enable and tx, clear eye and powersave.
// - check buffer free, send six preamble then six sync bytes with raw task.
// - send 10 header, 12 middle and 8 final bytes with their tasks.
// - wait 2 plus 16 symbol times after drain before ending transmission.
// - set checksum-form and shape bits on every command byte write.
// - before receive load control fields, irq enable on, tx, powersave, eye off.
// - with wide pll and track, wait 8 symbols of carrier before acquiring.
// - check buffer free, then seek sync and header with both acquire bits.
// - each receive interrupt: check free and no overflow, read bytes, next task.
// - after first receive interrupt switch pll bandwidth from wide to medium.
// - later frames: seek with acquire bits clear, pll medium, level track; the code writes cfg_r as software set it, with no pll or level override.
// - transmitter adds about 100 symbols preamble when carrier detect lacks.
module fskh_ctrl #(
  parameter        MEM_AW     = 6,
  parameter [19:0] SYM_CYCLES = (`SYM_NS + `CLK_NS - 1) / `CLK_NS
) (
  input  wire       MCLK,
  input  wire       RESET_N,
  input  wire [2:0] ADDR,
  input  wire [7:0] WDATA,
  input  wire       WR,
  input  wire       RD,
  output reg  [7:0] RDATA,
  output reg  [1:0] DEV_A,
  output reg        DEV_CS_N,
  output reg        DEV_RD_N,
  output reg        DEV_WR_N,
  input  wire [7:0] DEV_D_IN,
  output reg  [7:0] DEV_D_OUT,
  output reg        DEV_D_OE_N,
  input  wire       DEV_IRQ_N,
  input  wire       CARRIER,
  output wire       BUSY
);

  localparam [3:0] S_IDLE = 4'h0;
  localparam [3:0] S_CTRL = 4'h1;
  localparam [3:0] S_MODE = 4'h2;
  localparam [3:0] S_CARR = 4'h3;
  localparam [3:0] S_CHK  = 4'h4;
  localparam [3:0] S_LOAD = 4'h5;
  localparam [3:0] S_TASK = 4'h6;
  localparam [3:0] S_WIRQ = 4'h7;
  localparam [3:0] S_STAT = 4'h8;
  localparam [3:0] S_MED  = 4'h9;
  localparam [3:0] S_RDB  = 4'ha;
  localparam [3:0] S_TAIL = 4'hb;

  localparam [2:0] G_PRE  = 3'h0;
  localparam [2:0] G_SYNC = 3'h1;
  localparam [2:0] G_HEAD = 3'h2;
  localparam [2:0] G_MID  = 3'h3;
  localparam [2:0] G_LAST = 3'h4;

  localparam [19:0] CARR_LOAD = `CARRIER_SYMS * SYM_CYCLES;
  localparam [19:0] TAIL_LOAD = `TAIL_SYMS * SYM_CYCLES;

  reg [7:0]        mem [0:(1<<MEM_AW)-1];
  reg [3:0]        state_r;
  reg [2:0]        seg_r;
  reg [1:0]        pre_left_r;
  reg [7:0]        blk_left_r;
  reg [4:0]        cnt_r;
  reg [19:0]       tmr_r;
  reg [MEM_AW-1:0] ptr_r;
  reg [MEM_AW-1:0] sw_ptr_r;
  reg              rx_r;
  reg              acq_r;
  reg              drain_r;
  reg              done_r;
  reg              crc_err_r;
  reg [2:0]        err_r;
  reg [7:0]        cfg_r;
  reg [2:0]        opt_r;
  reg [7:0]        nblk_r;
  reg [7:0]        dev_stat_r;
  reg              irq_m_r;
  reg              irq_s_r;
  reg              car_m_r;
  reg              car_s_r;
  reg [7:0]        din_m_r;
  reg [7:0]        din_s_r;
  reg              bbusy_r;
  reg              bdone_r;
  reg [2:0]        bcnt_r;
  reg [7:0]        brd_r;

  reg              op_req;
  reg              op_wr;
  reg [1:0]        op_addr;
  reg [7:0]        op_data;
  reg [3:0]        task_code;
  reg [4:0]        seg_len;
  reg [2:0]        seg_next;

  wire sw_wr_data = WR && (ADDR == `SW_DATA) && (state_r == S_IDLE);
  wire rx_wr      = (state_r == S_RDB) && bdone_r;
  wire first_rx   = rx_r && (seg_r == G_HEAD);
  wire [7:0] cmd_byte = {acq_r & first_rx, acq_r & first_rx,
                         opt_r[`OPT_CRCF], opt_r[`OPT_SHAPE], task_code};

  assign BUSY = (state_r != S_IDLE);

  // pins are asynchronous: two flops before any use
  always @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      irq_m_r <= 1'b0;
      irq_s_r <= 1'b0;
      car_m_r <= 1'b0;
      car_s_r <= 1'b0;
      din_m_r <= 8'h00;
      din_s_r <= 8'h00;
    end else begin
      irq_m_r <= ~DEV_IRQ_N;
      irq_s_r <= irq_m_r;
      car_m_r <= CARRIER;
      car_s_r <= car_m_r;
      din_m_r <= DEV_D_IN;
      din_s_r <= din_m_r;
    end
  end

  always @* begin
    case (seg_r)
      G_PRE, G_SYNC: seg_len = `LEN_SYNC;
      G_HEAD:        seg_len = `LEN_HEAD;
      G_MID:         seg_len = `LEN_MID;
      default:       seg_len = `LEN_LAST;
    endcase
    case (seg_r)
      G_PRE:   seg_next = G_SYNC;
      G_SYNC:  seg_next = G_HEAD;
      default: seg_next = (blk_left_r != 8'h00) ? G_MID : G_LAST;
    endcase
    if (rx_r)
      task_code = first_rx ? `TASK_SEEK_HDR : `TASK_RX_BLK;
    else begin
      case (seg_r)
        G_PRE, G_SYNC: task_code = `TASK_RAW24;
        G_HEAD:        task_code = `TASK_HDR;
        G_MID:         task_code = `TASK_MID;
        default:       task_code = `TASK_FINAL;
      endcase
    end
  end

  always @* begin
    op_req  = 1'b1;
    op_wr   = 1'b1;
    op_addr = `DEV_A_CMD;
    op_data = 8'h00;
    case (state_r)
      S_CTRL: begin
        op_addr = `DEV_A_CTRL;
        op_data = cfg_r;
        if (rx_r && acq_r) begin
          op_data[`PLL_LSB+1:`PLL_LSB] = `PLL_WIDE;
          op_data[`LEV_LSB+1:`LEV_LSB] = `LEV_TRACK;
        end
      end
      S_MED: begin
        op_addr = `DEV_A_CTRL;
        op_data = cfg_r;
        op_data[`PLL_LSB+1:`PLL_LSB] = `PLL_MED;
        op_data[`LEV_LSB+1:`LEV_LSB] = `LEV_TRACK;
      end
      S_MODE: begin
        op_addr = `DEV_A_MODE;
        op_data[`MD_IRQ_OUTPUT_ENABLE] = 1'b1;
        op_data[`MD_TX]    = ~rx_r;
        op_data[`MD_INV]   = opt_r[`OPT_INV];
      end
      S_CHK, S_STAT: op_wr = 1'b0;
      S_LOAD: begin
        op_addr = `DEV_A_DATA;
        op_data = mem[ptr_r];
      end
      S_TASK: op_data = cmd_byte;
      S_RDB: begin
        op_wr   = 1'b0;
        op_addr = `DEV_A_DATA;
      end
      default: op_req = 1'b0;
    endcase
  end

  // one device access lasts BUS_CYC cycles; read data leave through the
  // synchroniser, so the device must present them within two cycles
  always @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      bbusy_r    <= 1'b0;
      bdone_r    <= 1'b0;
      bcnt_r     <= 3'h0;
      brd_r      <= 8'h00;
      DEV_A      <= 2'h0;
      DEV_CS_N   <= 1'b1;
      DEV_RD_N   <= 1'b1;
      DEV_WR_N   <= 1'b1;
      DEV_D_OUT  <= 8'h00;
      DEV_D_OE_N <= 1'b1;
    end else begin
      bdone_r <= 1'b0;
      if (bbusy_r) begin
        if (bcnt_r == 3'h0) begin
          bbusy_r    <= 1'b0;
          bdone_r    <= 1'b1;
          brd_r      <= din_s_r;
          DEV_CS_N   <= 1'b1;
          DEV_RD_N   <= 1'b1;
          DEV_WR_N   <= 1'b1;
          DEV_D_OE_N <= 1'b1;
        end else
          bcnt_r <= bcnt_r - 3'h1;
      end else if (op_req && !bdone_r) begin
        bbusy_r    <= 1'b1;
        bcnt_r     <= `BUS_CYC - 3'h1;
        DEV_A      <= op_addr;
        DEV_D_OUT  <= op_data;
        DEV_CS_N   <= 1'b0;
        DEV_RD_N   <= op_wr;
        DEV_WR_N   <= ~op_wr;
        DEV_D_OE_N <= ~op_wr;
      end
    end
  end

  always @(posedge MCLK) begin
    if (rx_wr)
      mem[ptr_r] <= brd_r;
    else if (sw_wr_data)
      mem[sw_ptr_r] <= WDATA;
  end

  // software register port
  always @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cfg_r    <= 8'h00;
      opt_r    <= 3'h0;
      nblk_r   <= 8'h00;
      sw_ptr_r <= {MEM_AW{1'b0}};
      RDATA    <= 8'h00;
    end else begin
      RDATA <= 8'h00;
      if (WR && !BUSY) begin
        case (ADDR)
          `SW_CFG:  cfg_r <= WDATA;
          `SW_OPT:  opt_r <= WDATA[2:0];
          `SW_NBLK: nblk_r <= WDATA;
          `SW_PTR:  sw_ptr_r <= WDATA[MEM_AW-1:0];
          `SW_DATA: sw_ptr_r <= sw_ptr_r + 1'b1;
          default:  ;
        endcase
      end else if (RD) begin
        case (ADDR)
          `SW_CFG:  RDATA <= cfg_r;
          `SW_OPT:  RDATA <= {5'h00, opt_r};
          `SW_NBLK: RDATA <= nblk_r;
          `SW_STAT: RDATA <= {BUSY, done_r, crc_err_r, err_r, rx_r, drain_r};
          `SW_PTR:  RDATA <= {{(8-MEM_AW){1'b0}}, sw_ptr_r};
          `SW_DATA: RDATA <= mem[sw_ptr_r];
          `SW_DEV:  RDATA <= dev_stat_r;
          default:  RDATA <= 8'h00;
        endcase
        if (ADDR == `SW_DATA && !BUSY)
          sw_ptr_r <= sw_ptr_r + 1'b1;
      end
    end
  end

  // frame sequencer
  always @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_r    <= S_IDLE;
      seg_r      <= G_PRE;
      pre_left_r <= 2'h0;
      blk_left_r <= 8'h00;
      cnt_r      <= 5'h00;
      tmr_r      <= 20'h00000;
      ptr_r      <= {MEM_AW{1'b0}};
      rx_r       <= 1'b0;
      acq_r      <= 1'b0;
      drain_r    <= 1'b0;
      done_r     <= 1'b0;
      crc_err_r  <= 1'b0;
      err_r      <= `ERR_NONE;
      dev_stat_r <= 8'h00;
    end else begin
      if (tmr_r != 20'h00000)
        tmr_r <= tmr_r - 20'h00001;
      case (state_r)
        S_IDLE: if (WR && ADDR == `SW_GO && (WDATA[`GO_TX] || WDATA[`GO_RX])) begin
          rx_r       <= ~WDATA[`GO_TX];
          acq_r      <= WDATA[`GO_ACQ];
          pre_left_r <= WDATA[`GO_LONG] ? `PRE_REPEAT : 2'h0;
          seg_r      <= WDATA[`GO_TX] ? G_PRE : G_HEAD;
          blk_left_r <= nblk_r;
          ptr_r      <= {MEM_AW{1'b0}};
          drain_r    <= 1'b0;
          done_r     <= 1'b0;
          crc_err_r  <= 1'b0;
          err_r      <= `ERR_NONE;
          state_r    <= S_CTRL;
        end
        S_CTRL: if (bdone_r) state_r <= S_MODE;
        S_MODE: if (bdone_r) begin
          tmr_r   <= CARR_LOAD;
          state_r <= (rx_r && acq_r) ? S_CARR : S_CHK;
        end
        S_CARR: begin
          if (!car_s_r)
            tmr_r <= CARR_LOAD;
          else if (tmr_r == 20'h00000)
            state_r <= S_CHK;
        end
        S_CHK: if (bdone_r) begin
          dev_stat_r <= brd_r;
          cnt_r      <= seg_len;
          if (!brd_r[`ST_FREE]) begin
            err_r   <= `ERR_NOTFREE;
            state_r <= S_IDLE;
          end else
            state_r <= rx_r ? S_TASK : S_LOAD;
        end
        S_LOAD: if (bdone_r) begin
          ptr_r <= ptr_r + 1'b1;
          cnt_r <= cnt_r - 5'h01;
          if (cnt_r == 5'h01)
            state_r <= S_TASK;
        end
        // guard covers the synchroniser lag after the releasing status read
        S_TASK: if (bdone_r) begin
          tmr_r   <= `IRQ_GUARD;
          state_r <= S_WIRQ;
        end
        S_WIRQ: if (tmr_r == 20'h00000 && irq_s_r) state_r <= S_STAT;
        S_STAT: if (bdone_r) begin
          dev_stat_r <= brd_r;
          if (!rx_r && drain_r) begin
            if (brd_r[`ST_IRQ] && brd_r[`ST_FREE] && brd_r[`ST_INTERLEAVE_EMPTY_FLAG]) begin
              tmr_r   <= TAIL_LOAD;
              state_r <= S_TAIL;
            end else begin
              err_r   <= `ERR_TXFLAGS;
              state_r <= S_IDLE;
            end
          end else if (!rx_r) begin
            if (!brd_r[`ST_IRQ] || !brd_r[`ST_FREE] || brd_r[`ST_INTERLEAVE_EMPTY_FLAG]) begin
              err_r   <= `ERR_TXFLAGS;
              state_r <= S_IDLE;
            end else if (seg_r == G_PRE && pre_left_r != 2'h0) begin
              // no carrier detect at the far end: resend the same six bytes
              pre_left_r <= pre_left_r - 2'h1;
              ptr_r      <= {MEM_AW{1'b0}};
              cnt_r      <= `LEN_SYNC;
              state_r    <= S_LOAD;
            end else if (seg_r == G_LAST) begin
              drain_r <= 1'b1;
              tmr_r   <= `IRQ_GUARD;
              state_r <= S_WIRQ;
            end else begin
              seg_r <= seg_next;
              if (seg_r != G_PRE && seg_r != G_SYNC && blk_left_r != 8'h00)
                blk_left_r <= blk_left_r - 8'h01;
              cnt_r   <= (seg_next == G_SYNC) ? `LEN_SYNC :
                         (seg_next == G_HEAD) ? `LEN_HEAD :
                         (seg_next == G_MID)  ? `LEN_MID : `LEN_LAST;
              state_r <= S_LOAD;
            end
          end else begin
            cnt_r <= seg_len;
            if (!brd_r[`ST_IRQ] || !brd_r[`ST_FREE] || brd_r[`ST_OVF]) begin
              err_r   <= `ERR_RXFLAGS;
              state_r <= S_IDLE;
            end else begin
              if (seg_r != G_MID && brd_r[`ST_CRC])
                crc_err_r <= 1'b1;
              state_r <= (first_rx && acq_r) ? S_MED : S_RDB;
            end
          end
        end
        S_MED: if (bdone_r) state_r <= S_RDB;
        S_RDB: if (bdone_r) begin
          ptr_r <= ptr_r + 1'b1;
          cnt_r <= cnt_r - 5'h01;
          if (cnt_r == 5'h01) begin
            if (seg_r == G_LAST) begin
              done_r  <= 1'b1;
              state_r <= S_IDLE;
            end else begin
              seg_r <= seg_next;
              if (blk_left_r != 8'h00)
                blk_left_r <= blk_left_r - 8'h01;
              state_r <= S_TASK;
            end
          end
        end
        S_TAIL: if (tmr_r == 20'h00000) begin
          done_r  <= 1'b1;
          state_r <= S_IDLE;
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

endmodule // fskh_ctrl

`default_nettype wire

// >>> fskh_ctrl_asserts.sv
// checker for the fsk host controller: device bus timing and task order.
// assumes it is bound to fskh_ctrl and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
`include "fskh_regs.vh"
module fskh_ctrl_chk #(
  parameter [19:0] SYM_CYCLES = 20'd4
) (
  input wire logic       MCLK,
  input wire logic       RESET_N,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  input wire logic [1:0] DEV_A,
  input wire logic       DEV_CS_N,
  input wire logic       DEV_RD_N,
  input wire logic       DEV_WR_N,
  input wire logic [7:0] DEV_D_IN,
  input wire logic [7:0] DEV_D_OUT,
  input wire logic       DEV_D_OE_N,
  input wire logic       CARRIER,
  input wire logic       BUSY
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESET_N);
  logic        free_r, rx_ok_r, drain_r, wr_n_q;
  logic [19:0] car_r, tail_r;
  wire         st_rd  = !DEV_CS_N && !DEV_RD_N && DEV_A == `DEV_A_CMD;
  wire         cmd_wr = !DEV_CS_N && !DEV_WR_N && DEV_A == `DEV_A_CMD;
  // write strobe falling edge, taken from a flop of the previous level
  wire         wr_go  = wr_n_q && !DEV_WR_N;
  // raw carrier runs ahead of the synchronised one, so the bound is lenient
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      {free_r, rx_ok_r, drain_r} <= 3'h0;
      wr_n_q <= 1'b1;
      car_r <= 20'd0;
      tail_r <= 20'd0;
    end else begin
      wr_n_q <= DEV_WR_N;
      car_r <= !CARRIER ? 20'd0 : (&car_r ? car_r : car_r + 20'd1);
      tail_r <= st_rd ? 20'd0 : (&tail_r ? tail_r : tail_r + 20'd1);
      if (st_rd) begin
        free_r <= DEV_D_IN[`ST_FREE];
        rx_ok_r <= DEV_D_IN[`ST_FREE] && !DEV_D_IN[`ST_OVF];
        drain_r <= &DEV_D_IN[7:5];
      end else begin
        if (cmd_wr)
          free_r <= 1'b0;
        if (!BUSY)
          drain_r <= 1'b0;
      end
    end
  end
  chk_cs_len: assert property ($fell(DEV_CS_N) |-> (!DEV_CS_N) [*4] ##1 DEV_CS_N)
    else $error("device select not four cycles");
  chk_access_gap: assert property ($rose(DEV_CS_N) |-> DEV_CS_N [*2])
    else $error("device accesses too close");
  chk_access_hold: assert property (!DEV_CS_N && !$fell(DEV_CS_N) |->
    $stable(DEV_A) && $stable(DEV_D_OUT) && $stable({DEV_RD_N, DEV_WR_N}))
    else $error("device access changed mid cycle");
  chk_drive_write: assert property (!DEV_D_OE_N |-> !DEV_CS_N && DEV_RD_N)
    else $error("data driven outside a write");
  chk_rdata_idle: assert property (!$past(RD) |-> RDATA == 8'h00)
    else $error("read data outside its cycle");
  chk_task_code: assert property (wr_go && DEV_A == `DEV_A_CMD |->
    DEV_D_OUT[3:0] inside {4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h7})
    else $error("illegal task code");
  chk_mode_bits: assert property (wr_go && DEV_A == `DEV_A_MODE |-> DEV_D_OUT[`MD_IRQ_OUTPUT_ENABLE]
    && !DEV_D_OUT[`MD_EYE] && !DEV_D_OUT[`MD_POWER_SAVE_BIT] && DEV_D_OUT[2:0] == 3'h0)
    else $error("bad mode byte");
  chk_free_first: assert property (wr_go && DEV_A == `DEV_A_CMD |-> free_r)
    else $error("task written without buffer free");
  chk_rx_read: assert property ($fell(DEV_RD_N) && DEV_A == `DEV_A_DATA |-> rx_ok_r)
    else $error("data read without free or with overflow");
  chk_carrier_wait: assert property (wr_go && DEV_A == `DEV_A_CMD && DEV_D_OUT[`CMD_AUTO_CLOCK_ACQUIRE_BIT]
    |-> car_r >= 8 * SYM_CYCLES)
    else $error("acquire started before carrier settled");
  chk_tail_wait: assert property ($fell(BUSY) && drain_r |-> tail_r >= 18 * SYM_CYCLES - 4)
    else $error("transmit ended before filter flushed");
endmodule // fskh_ctrl_chk
bind fskh_ctrl fskh_ctrl_chk #(.SYM_CYCLES(SYM_CYCLES)) chk_u (.*);
`default_nettype wire

// >>> fskh_ctrl_tb.sv
// self-checking bench: software port tasks driving whole frames.
// assumes fskh_dev_model on the device side and SYM_CYCLES of 4.
`timescale 1ns/1ps
`default_nettype none
`include "fskh_regs.vh"
module fskh_ctrl_tb;
  localparam int SYM = 4;
  logic       MCLK, RESET_N, WR, RD, CARRIER, BUSY, DEV_CS_N, DEV_RD_N, DEV_WR_N;
  logic       DEV_D_OE_N, DEV_IRQ_N, slow, stuck_busy, ovf_bad, crc_bad;
  logic [2:0] ADDR;
  logic [1:0] DEV_A;
  logic [7:0] WDATA, RDATA, DEV_D_IN, DEV_D_OUT, v;
  int         n_fail, total_checks, i, k, t0, p;
  fskh_ctrl #(.SYM_CYCLES(20'd4)) dut_u (.*);
  fskh_dev_model dev_u (.*);
  initial begin
    MCLK = 1'b0;
    forever #50 MCLK = ~MCLK;
  end
  task automatic sw_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge MCLK);
    {ADDR, WDATA, WR} <= {a, d, 1'b1};
    @(posedge MCLK);
    WR <= 1'b0;
  endtask
  task automatic sw_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge MCLK);
    {ADDR, RD} <= {a, 1'b1};
    @(posedge MCLK);
    RD <= 1'b0;
    #1 d = RDATA;
  endtask
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_ge(input string nm, input int lo, input int g);
    total_checks++;
    if (g < lo) begin
      n_fail++;
      $display("CHECK FAILED %s expected at least %0d seen %0d", nm, lo, g);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // bounded wait for the sequencer to finish a frame
  task automatic run_frame(input logic [7:0] go);
    sw_wr(`SW_GO, go);
    repeat (3) @(posedge MCLK);
    for (int j = 0; j < 20000 && BUSY !== 1'b0; j++)
      @(posedge MCLK);
    if (BUSY !== 1'b0) begin
      n_fail++;
      $display("CHECK FAILED busy expected 0 seen %b", BUSY);
      wrap_up();
    end
  endtask
  initial begin
    {WR, RD, CARRIER, slow, stuck_busy, ovf_bad, crc_bad, RESET_N} = '0;
    {ADDR, WDATA, n_fail, total_checks} = '0;
    repeat (12) @(posedge MCLK);
    RESET_N <= 1'b1;
    for (k = 0; k < 2; k++) begin
      slow <= k[0];
      sw_wr(`SW_PTR, 8'h00);
      for (i = 0; i < 42 + 12 * k; i++)
        sw_wr(`SW_DATA, 8'(i * 5 + k));
      sw_wr(`SW_CFG, 8'h05);
      sw_wr(`SW_OPT, k ? 8'h00 : 8'h07);
      sw_wr(`SW_NBLK, 8'(k + 1));
      p = k ? 0 : 3;
      run_frame(k ? 8'h01 : 8'h09);
      chk_ge("tail", dev_u.drain_cyc + 18 * SYM, dev_u.cyc);
      chk8("mode", k ? 8'hc0 : 8'he0, dev_u.mode_r);
      chk8("divider", 8'h05, dev_u.ctrl_r);
      chk8("tx count", 8'(42 + 12 * k + 6 * p), 8'(dev_u.n_tx));
      for (i = 0; i < 42 + 12 * k + 6 * p; i++)
        chk8("tx byte", 8'((i < 6 * p + 6 ? i % 6 : i - 6 * p) * 5 + k),
             dev_u.tx_mem[i]);
      chk8("task count", 8'(5 + k + p), 8'(dev_u.n_cmd));
      for (i = 0; i < 5 + k + p; i++) begin
        v = {4'h0, i < 2 + p ? `TASK_RAW24 : i == 2 + p ? `TASK_HDR :
                   i == 4 + k + p ? `TASK_FINAL : `TASK_MID};
        chk8("tx task", v | (k ? 8'h00 : 8'h30), dev_u.cmd_log[i]);
      end
      sw_rd(`SW_STAT, v);
      chk8("tx stat", 8'h40, v & 8'hfc);
      $display("tx frame %0d done", k);
    end
    slow <= 1'b0;
    CARRIER <= 1'b1;
    t0 = dev_u.cyc;
    sw_wr(`SW_CFG, 8'h05);
    sw_wr(`SW_OPT, 8'h02);
    sw_wr(`SW_NBLK, 8'h01);
    run_frame(8'h06);
    chk_ge("carrier wait", t0 + 8 * SYM, dev_u.cmd_cyc);
    chk8("seek task", 8'hd1, dev_u.cmd_log[0]);
    chk8("block task", 8'h12, dev_u.cmd_log[1]);
    chk8("last task", 8'h12, dev_u.cmd_log[2]);
    chk8("pll", {6'h0, `PLL_MED}, {6'h0, dev_u.ctrl_r[7:6]});
    chk8("rx mode", 8'h80, dev_u.mode_r);
    sw_wr(`SW_PTR, 8'h00);
    for (i = 0; i < 30; i++) begin
      sw_rd(`SW_DATA, v);
      chk8("rx byte", 8'ha0 + 8'(i), v);
    end
    sw_rd(`SW_STAT, v);
    chk8("rx stat", 8'h40, v & 8'hfc);
    $display("rx acquire frame done");
    CARRIER <= 1'b0;
    crc_bad <= 1'b1;
    sw_wr(`SW_CFG, 8'h45);
    sw_wr(`SW_OPT, 8'h00);
    sw_wr(`SW_NBLK, 8'h00);
    run_frame(8'h02);
    chk8("plain seek", 8'h01, dev_u.cmd_log[0]);
    chk8("plain ctrl", 8'h45, dev_u.ctrl_r);
    chk8("plain count", 8'h02, 8'(dev_u.n_cmd));
    sw_rd(`SW_STAT, v);
    chk8("crc stat", 8'h60, v & 8'hfc);
    $display("rx plain frame done");
    stuck_busy <= 1'b1;
    run_frame(8'h01);
    sw_rd(`SW_STAT, v);
    chk8("busy err", {5'h0, `ERR_NOTFREE}, {5'h0, v[4:2]});
    chk8("no task", 8'h00, 8'(dev_u.n_cmd));
    stuck_busy <= 1'b0;
    ovf_bad <= 1'b1;
    run_frame(8'h02);
    sw_rd(`SW_STAT, v);
    chk8("ovf err", {5'h0, `ERR_RXFLAGS}, {5'h0, v[4:2]});
    $display("error frames done");
    wrap_up();
  end
endmodule // fskh_ctrl_tb
`default_nettype wire

// >>> fskh_dev_model.sv
// behavioural model of the modem seen through its parallel port.
// assumes the controller's 4-cycle accesses; delays in MCLK cycles.
`timescale 1ns/1ps
`default_nettype none
`include "fskh_regs.vh"
module fskh_dev_model (
  input  wire logic       MCLK,
  input  wire logic       RESET_N,
  input  wire logic [1:0] DEV_A,
  input  wire logic       DEV_CS_N,
  input  wire logic       DEV_RD_N,
  input  wire logic       DEV_WR_N,
  input  wire logic [7:0] DEV_D_OUT,
  input  wire logic       DEV_D_OE_N,
  input  wire logic       slow,
  input  wire logic       stuck_busy,
  input  wire logic       ovf_bad,
  input  wire logic       crc_bad,
  output logic      [7:0] DEV_D_IN,
  output logic            DEV_IRQ_N
);
  logic       irq, free, ibe, ovf, crc, wr_q, rd_q;
  logic [7:0] mode_r, ctrl_r, d_q, last_r;
  logic [7:0] cmd_log [0:15];
  logic [7:0] tx_mem [0:63];
  logic [1:0] a_q;
  logic [3:0] task_r;
  int         cnt, dcnt, cyc, n_cmd, n_tx, n_rx, cmd_cyc, drain_cyc;
  wire        wr_on = !DEV_CS_N && !DEV_WR_N;
  wire        rd_on = !DEV_CS_N && !DEV_RD_N;
  wire  [7:0] stat  = {irq, free, ibe, ovf, crc, 3'h0};
  // released bus shows a toggling pattern so a stale sample cannot pass
  assign DEV_D_IN = rd_on ? (DEV_A == `DEV_A_CMD ? stat : 8'ha0 + n_rx[7:0])
                  : (!DEV_D_OE_N ? DEV_D_OUT : ~last_r);
  assign DEV_IRQ_N = !(irq && mode_r[`MD_IRQ_OUTPUT_ENABLE]);
  always @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      {irq, ovf, crc, wr_q, rd_q, free, ibe} <= 7'h03;
      {mode_r, ctrl_r, last_r, task_r} <= '0;
      {cnt, dcnt, cyc, n_cmd, n_tx, n_rx} <= '0;
    end else begin
      cyc <= cyc + 1;
      last_r <= DEV_D_IN;
      wr_q <= wr_on;
      rd_q <= rd_on;
      if (!DEV_CS_N)
        {a_q, d_q} <= {DEV_A, DEV_D_OUT};
      if (rd_q && !rd_on && a_q == `DEV_A_CMD)
        {irq, ovf} <= 2'h0;
      else if (rd_q && !rd_on)
        n_rx <= n_rx + 1;
      if (wr_q && !wr_on) case (a_q)
        `DEV_A_MODE: begin
          mode_r <= d_q;
          {free, ibe, ovf, crc} <= {!stuck_busy, 3'h4};
          {n_cmd, n_tx, n_rx} <= '0;
        end
        `DEV_A_CTRL: ctrl_r <= d_q;
        `DEV_A_DATA: begin
          tx_mem[n_tx[5:0]] <= d_q;
          n_tx <= n_tx + 1;
        end
        default: if (d_q[3:0] != 4'h0) begin
          // shape bit of each task is kept in the log for the bench
          {free, ibe, task_r} <= {2'h0, d_q[3:0]};
          cnt <= slow ? 300 : 20;
          cmd_log[n_cmd[3:0]] <= d_q;
          n_cmd <= n_cmd + 1;
          if (n_cmd == 0)
            cmd_cyc <= cyc;
        end
      endcase
      if (cnt > 0)
        cnt <= cnt - 1;
      if (cnt == 1) begin
        {free, irq} <= 2'h3;
        if (!mode_r[`MD_TX])
          {crc, ovf} <= {crc_bad, ovf_bad};
        else if (task_r == `TASK_FINAL)
          dcnt <= slow ? 300 : 20;
      end
      if (dcnt > 0)
        dcnt <= dcnt - 1;
      if (dcnt == 1) begin
        {ibe, irq} <= 2'h3;
        drain_cyc <= cyc;
      end
    end
  end
endmodule // fskh_dev_model
`default_nettype wire

// >>> fskh_regs.vh
// constants of the 4-level fsk modem host controller: device pin map,
// device byte layouts, task codes, block lengths, timing and software map.
// assumes the device sits on a small parallel port with 2 address lines.
`ifndef FSKH_REGS_VH
`define FSKH_REGS_VH

// device port addresses (command write and status read share one)
`define DEV_A_DATA    2'h0
`define DEV_A_CMD     2'h1
`define DEV_A_CTRL    2'h2
`define DEV_A_MODE    2'h3

// device status byte
`define ST_IRQ        7
`define ST_FREE       6
`define ST_INTERLEAVE_EMPTY_FLAG    5
`define ST_OVF        4
`define ST_CRC        3

// device mode byte, low three bits always zero
`define MD_IRQ_OUTPUT_ENABLE      7
`define MD_TX         6
`define MD_INV        5
`define MD_EYE        4
`define MD_POWER_SAVE_BIT      3

// command byte: task code in the low nibble
`define CMD_SHAPE     4
`define CMD_CRCF      5
`define CMD_AUTO_CLOCK_ACQUIRE_BIT      6
`define CMD_AUTO_LEVEL_ACQUIRE_BIT     7
`define TASK_SEEK_HDR 4'h1
`define TASK_RX_BLK   4'h2
`define TASK_RAW24    4'h4
`define TASK_HDR      4'h5
`define TASK_MID      4'h6
`define TASK_FINAL    4'h7

// device control byte fields
`define PLL_LSB       6
`define PLL_WIDE      2'h2
`define PLL_MED       2'h1
`define LEV_LSB       4
`define LEV_TRACK     2'h0

// block lengths in bytes
`define LEN_SYNC      5'd6
`define LEN_HEAD      5'd10
`define LEN_MID       5'd12
`define LEN_LAST      5'd8

// timing
`define CLK_NS        100
`define SYM_NS        208333
`define CARRIER_SYMS  8
`define TAIL_SYMS     18
`define BUS_CYC       3'd4
`define IRQ_GUARD     20'd3
// extra raw preamble tasks on a long preamble: 3, so 4 x 24 = 96 symbols in all
`define PRE_REPEAT    2'd3

// software register map
`define SW_GO         3'h0
`define SW_CFG        3'h1
`define SW_OPT        3'h2
`define SW_NBLK       3'h3
`define SW_STAT       3'h4
`define SW_PTR        3'h5
`define SW_DATA       3'h6
`define SW_DEV        3'h7
`define GO_TX         0
`define GO_RX         1
`define GO_ACQ        2
`define GO_LONG       3
`define OPT_INV       0
`define OPT_SHAPE     1
`define OPT_CRCF      2

// error codes
`define ERR_NONE      3'h0
`define ERR_NOTFREE   3'h1
`define ERR_TXFLAGS   3'h2
`define ERR_RXFLAGS   3'h3

`endif
